/* File: hw/awd_core.sv */
// Purpose: Register set, sample capture, data-ready and motion wake detection with interrupt pin
// Assumes: Raw axis samples come from converter logic on clk_sys; register port strobes are one cycle
// Notes:   Read data is registered and appears one cycle after the read strobe
module awd_core
	import awd_pkg::*;
#(
	parameter int unsigned OUT_PERIOD  = RATE_50_CYCLES,
	parameter int unsigned WAKE_PERIOD = RATE_50_CYCLES
)(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	// Converter samples
	input  wire logic [15:0] raw_x,
	input  wire logic [15:0] raw_y,
	input  wire logic [15:0] raw_z,
	// Interrupt pin and state
	output logic             first_interrupt_pin,
	output logic             run_active
);

	logic [7:0]  main_control_reg_q;
	logic [7:0]  motion_rate_reg_q;
	logic [7:0]  output_rate_reg_q;
	logic [7:0]  interrupt_pin_config_reg_q;
	logic [7:0]  motion_axis_mask_reg_q;
	logic [7:0]  motion_persist_count_q;
	logic [7:0]  motion_threshold_reg_q;
	logic [15:0] axis_q [3];
	logic [15:0] wake_prev_q [3];
	logic [31:0] out_cnt_q;
	logic [31:0] wake_cnt_q;
	logic        drdy_flag_q;
	logic        wake_flag_q;
	logic [7:0]  persist_q;
	logic [15:0] pulse_cnt_q;
	logic        pin_q;
	logic [7:0]  rdata_q;

	// Control decode
	wire         run_bit      = main_control_reg_q[MC_RUN_BIT];
	wire         full_res     = main_control_reg_q[MC_RES_BIT];
	wire         drdy_en      = main_control_reg_q[MC_DRDY_BIT];
	wire [1:0]   range_sel    = main_control_reg_q[MC_RANGE_HI:MC_RANGE_LO];
	wire         wake_en      = main_control_reg_q[MC_WAKE_BIT];
	wire         pulse_mode   = interrupt_pin_config_reg_q[PC_PULSE_BIT];
	wire         pin_high     = interrupt_pin_config_reg_q[PC_POL_BIT];
	wire         pin_en       = interrupt_pin_config_reg_q[PC_EN_BIT];
	wire [15:0]  raw [3];
	assign raw[0] = raw_x;
	assign raw[1] = raw_y;
	assign raw[2] = raw_z;

	// Rate ticks; periods come from OUT_PERIOD and WAKE_PERIOD whatever rate code is written
	wire         out_tick     = run_bit && (out_cnt_q == OUT_PERIOD - 1);
	wire         wake_tick    = run_bit && wake_en && (wake_cnt_q == WAKE_PERIOD - 1);

	// Register port decode
	wire         wr_main      = reg_wr && (reg_addr == ADDR_MAIN_CTRL);
	wire         wr_mrate     = reg_wr && (reg_addr == ADDR_MOTION_RATE);
	wire         wr_orate     = reg_wr && (reg_addr == ADDR_OUT_RATE);
	wire         wr_pcfg      = reg_wr && (reg_addr == ADDR_PIN_CFG);
	wire         wr_mask      = reg_wr && (reg_addr == ADDR_AXIS_MASK);
	wire         wr_pers      = reg_wr && (reg_addr == ADDR_PERSIST);
	wire         wr_thr       = reg_wr && (reg_addr == ADDR_THRESHOLD);
	wire         release_rd   = reg_rd && (reg_addr == ADDR_INT_RELEASE);

	// Threshold in sample counts: 16 counts/g scaled to the selected range
	wire [4:0]   thr_shift    = 5'(THR_SHIFT) - 5'(range_sel);
	// Wide enough for the largest code at the finest scale, so no level wraps to zero
	wire [17:0]  thr_counts   = 18'(({10'h000, motion_threshold_reg_q} << thr_shift));

	// Per-axis motion against the previous wake sample
	logic [5:0]  dir_hit;
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_axis
			wire signed [16:0] diff = 17'($signed(raw[g])) - 17'($signed(wake_prev_q[g]));
			wire               pos  = diff > $signed({1'b0, thr_counts});
			wire               neg  = diff < -$signed({1'b0, thr_counts});
			assign dir_hit[5 - 2 * g] = neg && motion_axis_mask_reg_q[5 - 2 * g];
			assign dir_hit[4 - 2 * g] = pos && motion_axis_mask_reg_q[4 - 2 * g];
		end
	endgenerate
	wire         motion       = |dir_hit;
	wire [7:0]   persist_inc  = persist_q + 8'h01;
	wire         wake_event   = wake_tick && motion && (persist_inc >= motion_persist_count_q);
	wire         drdy_event   = out_tick && drdy_en;
	wire         any_event    = drdy_event || wake_event;
	wire         int_state    = drdy_flag_q || wake_flag_q;

	// Readback selection; low bytes read zero in 8-bit resolution
	wire [7:0]   low_mask     = full_res ? 8'hFF : 8'h00;
	wire [7:0]   status_val   = 8'(int_state) << ST_INT_BIT;
	logic [7:0]  rd_sel;
	always_comb
	begin
		case (reg_addr)
			ADDR_X_LOW:       rd_sel = axis_q[0][7:0] & low_mask;
			ADDR_X_HIGH:      rd_sel = axis_q[0][15:8];
			ADDR_Y_LOW:       rd_sel = axis_q[1][7:0] & low_mask;
			ADDR_Y_HIGH:      rd_sel = axis_q[1][15:8];
			ADDR_Z_LOW:       rd_sel = axis_q[2][7:0] & low_mask;
			ADDR_Z_HIGH:      rd_sel = axis_q[2][15:8];
			ADDR_STATUS:      rd_sel = status_val;
			ADDR_MAIN_CTRL:   rd_sel = main_control_reg_q;
			ADDR_MOTION_RATE: rd_sel = motion_rate_reg_q;
			ADDR_OUT_RATE:    rd_sel = output_rate_reg_q;
			ADDR_PIN_CFG:     rd_sel = interrupt_pin_config_reg_q;
			ADDR_AXIS_MASK:   rd_sel = motion_axis_mask_reg_q;
			ADDR_PERSIST:     rd_sel = motion_persist_count_q;
			ADDR_THRESHOLD:   rd_sel = motion_threshold_reg_q;
			default:          rd_sel = 8'h00;
		endcase
	end

	// Configuration registers
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			main_control_reg_q         <= RST_MAIN_CTRL;
			motion_rate_reg_q          <= RST_MOTION_RATE;
			output_rate_reg_q          <= RST_OUT_RATE;
			interrupt_pin_config_reg_q <= RST_PIN_CFG;
			motion_axis_mask_reg_q     <= RST_AXIS_MASK;
			motion_persist_count_q     <= RST_PERSIST;
			motion_threshold_reg_q     <= RST_THRESHOLD;
		end
		else
		begin
			if (wr_main)  main_control_reg_q         <= reg_wdata;
			if (wr_mrate) motion_rate_reg_q          <= reg_wdata;
			if (wr_orate) output_rate_reg_q          <= reg_wdata;
			if (wr_pcfg)  interrupt_pin_config_reg_q <= reg_wdata;
			if (wr_mask)  motion_axis_mask_reg_q     <= reg_wdata;
			if (wr_pers)  motion_persist_count_q     <= reg_wdata;
			if (wr_thr)   motion_threshold_reg_q     <= reg_wdata;
		end
	end

	// Rate counters run only while operating
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			out_cnt_q  <= '0;
			wake_cnt_q <= '0;
		end
		else
		begin
			out_cnt_q  <= (!run_bit || out_tick) ? '0 : out_cnt_q + 32'h1;
			wake_cnt_q <= (!run_bit || !wake_en || wake_tick) ? '0 : wake_cnt_q + 32'h1;
		end
	end

	// Sample capture
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < 3; i++)
			begin
				axis_q[i]      <= '0;
				wake_prev_q[i] <= '0;
			end
		end
		else
		begin
			for (int i = 0; i < 3; i++)
			begin
				if (out_tick)
					axis_q[i] <= raw[i];
				if (wake_tick)
					wake_prev_q[i] <= raw[i];
			end
		end
	end

	// Event flags; a new event beats a release read in the same cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			drdy_flag_q <= 1'b0;
			wake_flag_q <= 1'b0;
			persist_q   <= '0;
		end
		else
		begin
			drdy_flag_q <= drdy_event || (drdy_flag_q && !release_rd);
			wake_flag_q <= wake_event || (wake_flag_q && !release_rd);
			if (!wake_en || !run_bit)
				persist_q <= '0;
			else if (wake_tick)
				persist_q <= motion ? persist_inc : 8'h00;
		end
	end

	// Interrupt pin: latched level or self-clearing pulse
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pulse_cnt_q <= '0;
			pin_q       <= 1'b0;
			rdata_q     <= 8'h00;
		end
		else
		begin
			if (any_event && pulse_mode)
				pulse_cnt_q <= 16'(PULSE_CYCLES);
			else if (pulse_cnt_q != '0)
				pulse_cnt_q <= pulse_cnt_q - 16'h1;
			pin_q   <= pin_en && (pulse_mode ? (any_event || pulse_cnt_q > 16'h1)
				: (any_event || (int_state && !release_rd)));
			if (reg_rd)
				rdata_q <= rd_sel;
		end
	end

	assign first_interrupt_pin = pin_high ? pin_q : !pin_q;
	assign reg_rdata           = rdata_q;
	assign run_active          = run_bit;

endmodule // awd_core

/* File: hw/awd_pkg.sv */
// Purpose: Shared constants for the acceleration sensor configuration and wake block
// Assumes: 50 MHz system clock, 8-bit register port
// Notes:   Register offsets are byte addresses on the register port
package awd_pkg;

	// Clock
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 20;

	// Register map
	localparam logic [7:0] ADDR_X_LOW       = 8'h06;
	localparam logic [7:0] ADDR_X_HIGH      = 8'h07;
	localparam logic [7:0] ADDR_Y_LOW       = 8'h08;
	localparam logic [7:0] ADDR_Y_HIGH      = 8'h09;
	localparam logic [7:0] ADDR_Z_LOW       = 8'h0A;
	localparam logic [7:0] ADDR_Z_HIGH      = 8'h0B;
	localparam logic [7:0] ADDR_STATUS      = 8'h15;
	localparam logic [7:0] ADDR_INT_RELEASE = 8'h17;
	localparam logic [7:0] ADDR_MAIN_CTRL   = 8'h18;
	localparam logic [7:0] ADDR_MOTION_RATE = 8'h1A;
	localparam logic [7:0] ADDR_OUT_RATE    = 8'h1B;
	localparam logic [7:0] ADDR_PIN_CFG     = 8'h1C;
	localparam logic [7:0] ADDR_AXIS_MASK   = 8'h1D;
	localparam logic [7:0] ADDR_PERSIST     = 8'h23;
	localparam logic [7:0] ADDR_THRESHOLD   = 8'h30;

	// Reset values
	localparam logic [7:0] RST_MAIN_CTRL    = 8'h00;
	localparam logic [7:0] RST_MOTION_RATE  = 8'h00;
	localparam logic [7:0] RST_OUT_RATE     = 8'h02;
	localparam logic [7:0] RST_PIN_CFG      = 8'h00;
	localparam logic [7:0] RST_AXIS_MASK    = 8'h00;
	localparam logic [7:0] RST_PERSIST      = 8'h00;
	localparam logic [7:0] RST_THRESHOLD    = 8'h00;

	// Main control fields
	localparam int unsigned MC_RUN_BIT      = 7;
	localparam int unsigned MC_RES_BIT      = 6;
	localparam int unsigned MC_DRDY_BIT     = 5;
	localparam int unsigned MC_RANGE_HI     = 4;
	localparam int unsigned MC_RANGE_LO     = 3;
	localparam int unsigned MC_WAKE_BIT     = 1;

	// Pin configuration fields
	localparam int unsigned PC_PULSE_BIT    = 3;
	localparam int unsigned PC_POL_BIT      = 4;
	localparam int unsigned PC_EN_BIT       = 5;

	// Status fields
	localparam int unsigned ST_INT_BIT      = 4;

	// Rate codes
	localparam logic [7:0] OUT_RATE_50HZ    = 8'h02;
	localparam logic [2:0] WAKE_RATE_50HZ   = 3'h6;
	localparam int unsigned RATE_50_HZ      = 50;

	// Threshold scaling: 16 counts per g, sample full scale 2g at 16 bit
	localparam int unsigned THR_SHIFT       = 10;

	// Pulse width on the interrupt pin, between 30 us and 50 us
	localparam int unsigned PULSE_NS        = 40_000;
	localparam int unsigned PULSE_CYCLES    = PULSE_NS / CLK_PERIOD_NS;

	// Sample period at 50 Hz
	localparam int unsigned RATE_50_CYCLES  = CLK_HZ / RATE_50_HZ;

endpackage : awd_pkg

/* File: verif/awd_host.sv */
// Purpose: Host model driving the register port
// Assumes: One-cycle strobes, read data one cycle after the read edge
// Notes:   Idle address and data are inverted so stale values never look valid
module awd_host
(
	input  wire logic       clk_sys,
	input  wire logic [7:0] reg_rdata,
	output logic      [7:0] reg_addr,
	output logic      [7:0] reg_wdata,
	output logic            reg_wr,
	output logic            reg_rd
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask
	task automatic idle();
		put(1'b0, 1'b0, ~reg_addr, ~reg_wdata);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		put(1'b0, 1'b1, a, 8'h00);
		idle();
		d = reg_rdata;
	endtask
endmodule // awd_host

/* File: verif/awd_monitor.sv */
// Purpose: Assertion checker on the ports of the sensor block
// Assumes: Pin setup is tracked from writes seen on the register port
// Notes:   Pulse limits of 30 us and 50 us taken at 50 MHz
module awd_monitor
	import awd_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst_n,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	// Interrupt pin and state
	input wire logic       first_interrupt_pin,
	input wire logic       run_active
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PULSE_MIN = 1500;
	localparam int PULSE_MAX = 2500;
	logic [7:0]  cfg_q;
	logic [15:0] cnt_q;
	wire         act = first_interrupt_pin == cfg_q[PC_POL_BIT];
	wire         rw_hit = reg_addr inside {ADDR_MAIN_CTRL, ADDR_MOTION_RATE, ADDR_OUT_RATE, ADDR_PIN_CFG,
		ADDR_AXIS_MASK, ADDR_PERSIST, ADDR_THRESHOLD};
	wire         main_wr = reg_wr && reg_addr == ADDR_MAIN_CTRL;
	always_ff @(posedge clk_sys or negedge rst_n)
		if (!rst_n)
		begin
			cfg_q <= 8'h00;
			cnt_q <= 16'h0000;
		end
		else
		begin
			if (reg_wr && reg_addr == ADDR_PIN_CFG)
				cfg_q <= reg_wdata;
			cnt_q <= act ? cnt_q + 16'h0001 : 16'h0000;
		end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	run_follow_a: assert property (main_wr |=> run_active == $past(reg_wdata[MC_RUN_BIT]))
		else $error("run state not taken from write");
	run_hold_a: assert property (!main_wr |=> $stable(run_active))
		else $error("run state moved without write");
	rw_back_a: assert property ((reg_wr && rw_hit) ##1 (reg_rd && reg_addr == $past(reg_addr))
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("register read back differs");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	pulse_max_a: assert property (cfg_q[PC_PULSE_BIT] && cfg_q[PC_EN_BIT] |-> cnt_q <= PULSE_MAX)
		else $error("pulse too long");
	pulse_min_a: assert property ($fell(act) && cfg_q[PC_PULSE_BIT] && cfg_q[PC_EN_BIT] |-> cnt_q >= PULSE_MIN)
		else $error("pulse too short");
	pin_off_a: assert property (!cfg_q[PC_EN_BIT] && !$past(cfg_q[PC_EN_BIT]) |-> !act)
		else $error("pin active while gated off");
	release_clear_a: assert property (reg_rd && reg_addr == ADDR_INT_RELEASE && !cfg_q[PC_PULSE_BIT]
		&& !run_active |=> !act) else $error("pin not cleared by release read");
endmodule // awd_monitor

bind awd_core awd_monitor u_awd_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.first_interrupt_pin(first_interrupt_pin), .run_active(run_active));

/* File: verif/test_accel_config_and_wake_detect.sv */
// Purpose: Self-checking bench for the sensor configuration and wake block
// Assumes: Short sample periods stand in for 50 Hz
// Notes:   Inputs change on the falling edge
module test_accel_config_and_wake_detect
	import awd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int OUT_P = 3000;
	localparam int WAKE_P = 50;
	localparam logic [7:0] RA [7] = '{ADDR_MAIN_CTRL, ADDR_MOTION_RATE, ADDR_OUT_RATE, ADDR_PIN_CFG,
		ADDR_AXIS_MASK, ADDR_PERSIST, ADDR_THRESHOLD};
	logic        clk_sys;
	logic        rst_n;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rv, d;
	logic        reg_wr, reg_rd, pin, run_active;
	logic [15:0] raw [3];
	logic [15:0] step = 16'h0000;
	int unsigned errors = 0;
	int unsigned checks_done = 0;
	int          n;
	awd_core #(.OUT_PERIOD(OUT_P), .WAKE_PERIOD(WAKE_P)) u_awd_core (.clk_sys(clk_sys), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.raw_x(raw[0]), .raw_y(raw[1]), .raw_z(raw[2]), .first_interrupt_pin(pin), .run_active(run_active));
	awd_host u_awd_host (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
	function automatic logic [7:0] axis_byte(input logic [15:0] s, input int hi);
		return hi ? s[15:8] : s[7:0];
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic close_out();
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic cycles(input int c);
		u_awd_host.idle();
		repeat (c) @(negedge clk_sys);
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		close_out();
	end
	always @(negedge clk_sys)
		raw[0] <= raw[0] + step;
	initial
	begin
		rst_n = 1'b0;
		void'($urandom(32'hF33C));
		raw[0] = 16'($urandom());
		raw[1] = 16'($urandom());
		raw[2] = 16'($urandom());
		repeat (6) @(negedge clk_sys);
		rst_n = 1'b1;
		foreach (RA[i])
		begin
			u_awd_host.rd(RA[i], rv);
			chk("reset value", (RA[i] == ADDR_OUT_RATE) ? RST_OUT_RATE : 8'h00, rv);
		end
		for (int i = 1; i < 7; i++)
		begin
			d = 8'($urandom());
			u_awd_host.wr(RA[i], d);
			u_awd_host.rd(RA[i], rv);
			chk("read back", d, rv);
		end
		u_awd_host.rd(8'hFF, rv);
		chk("unmapped", 8'h00, rv);
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'h40);
		u_awd_host.rd(ADDR_MAIN_CTRL, rv);
		chk("standby main", 8'h40, rv);
		chk("standby run", 8'h00, {7'h00, run_active});
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'hC0);
		cycles(OUT_P + 4);
		chk("running", 8'h01, {7'h00, run_active});
		for (int j = 0; j < 6; j++)
		begin
			u_awd_host.rd(ADDR_X_LOW + 8'(j), rv);
			chk("axis byte", axis_byte(raw[j / 2], j % 2), rv);
		end
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'h40);
		u_awd_host.wr(ADDR_PIN_CFG, 8'h38);
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'hE0);
		cycles(0);
		for (n = 0; pin !== 1'b1 && n < OUT_P + 10; n++)
			@(negedge clk_sys);
		chk("ready pulse seen", 8'h01, {7'h00, pin});
		for (n = 0; pin === 1'b1 && n < 3000; n++)
			@(negedge clk_sys);
		chk("pulse width", 8'h01, {7'h00, n >= 1500 && n <= 2500});
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'h42);
		u_awd_host.rd(ADDR_STATUS, rv);
		chk("ready status", 8'h01 << ST_INT_BIT, rv);
		// Ready flag is still set from the pulsed run; clear it before latched mode
		u_awd_host.rd(ADDR_INT_RELEASE, rv);
		u_awd_host.rd(ADDR_STATUS, rv);
		chk("ready cleared", 8'h00, rv);
		u_awd_host.wr(ADDR_PIN_CFG, 8'h30);
		u_awd_host.wr(ADDR_MOTION_RATE, 8'h06);
		u_awd_host.wr(ADDR_AXIS_MASK, 8'h7F);
		u_awd_host.wr(ADDR_PERSIST, 8'h05);
		u_awd_host.wr(ADDR_THRESHOLD, 8'h08);
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'hC2);
		step = 16'd180;
		cycles(190);
		chk("wake early", 8'h00, {7'h00, pin});
		cycles(210);
		chk("wake set", 8'h01, {7'h00, pin});
		u_awd_host.rd(ADDR_STATUS, rv);
		chk("wake status", 8'h01 << ST_INT_BIT, rv);
		step = 16'd100;
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'h42);
		u_awd_host.rd(ADDR_INT_RELEASE, rv);
		chk("released", 8'h00, {7'h00, pin});
		u_awd_host.rd(ADDR_STATUS, rv);
		chk("status released", 8'h00, rv);
		u_awd_host.wr(ADDR_MAIN_CTRL, 8'hC2);
		cycles(500);
		chk("below level", 8'h00, {7'h00, pin});
		close_out();
	end
endmodule // test_accel_config_and_wake_detect
